// File: inc/apd_pkg.sv
// constants, register map and carrier types of the amplifier supervisory block
// assumes a 100 MHz system clock and analog detectors that present plain logic levels
package apd_pkg;
  // clock and timing
  localparam int CLK_MHZ    = 100;
  localparam int START_US   = 1000;                 // start-up ramp length
  localparam int START_CYC  = START_US * CLK_MHZ;
  localparam int FMUTE_US   = 100;                  // fast mute before shut-down
  localparam int FMUTE_CYC  = FMUTE_US * CLK_MHZ;
  localparam int CNT_W      = 17;

  // register index on the plain port
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_FAULT_INDICATOR_OUTPUT = 3'h1;
  localparam logic [2:0] REG_TEMP = 3'h2;
  localparam logic [2:0] REG_STAT = 3'h3;
  localparam logic [2:0] REG_CH0  = 3'h4;           // channels at 4..7

  // control register fields
  localparam int CTRL_START     = 0;
  localparam int CTRL_DCLD      = 1;
  localparam int CTRL_ROUTE_LSB = 3;                // clip route ch0..ch3, 1 = standby pin
  // diagnostic selection fields
  localparam int FAULT_INDICATOR_OUTPUT_LVL_LSB   = 0;
  localparam int FAULT_INDICATOR_OUTPUT_LOAD_DIS  = 4;
  localparam int FAULT_INDICATOR_OUTPUT_TEMP_DIS  = 5;
  localparam int FAULT_INDICATOR_OUTPUT_CLIP_DIS  = 6;
  // temperature field
  localparam int TEMP_PW_SEL    = 4;
  // status fields
  localparam int STAT_PW        = 0;
  localparam int STAT_GR        = 1;
  localparam int STAT_LOWBAT    = 2;
  localparam int STAT_OV        = 3;
  localparam int STAT_TOFF      = 4;
  localparam int STAT_POR       = 7;
  // channel status fields
  localparam int CH_CLIP        = 0;
  localparam int CH_SHORT       = 1;
  localparam int CH_OFFS        = 2;
  localparam int CH_MISS        = 3;
  localparam int CH_LOAD_LSB    = 4;

  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [1:0] LOAD_NORMAL     = 2'h0;
  localparam logic [1:0] LOAD_LINE       = 2'h2;
  localparam logic [1:0] LOAD_OPEN       = 2'h3;
  localparam logic [1:0] CLIP_LVL_LEGACY = 2'h0;    // lowest clip level
  localparam logic       PW_SEL_LEGACY   = 1'b0;    // lower pre-warning level

  // analog detector results
  typedef struct packed {
    logic       vp_below_reset;
    logic       hr_low;
    logic       vp_low_mute;
    logic       low_bat;
    logic       over_volt;
    logic       svr_empty;
    logic       prewarn;
    logic       gain_red;
    logic       t_off;
    logic [3:0] short_ch;
    logic [3:0] miss_ch;
    logic [3:0] clip_ch;
    logic [3:0] in_window;
    logic [3:0] i_open;
    logic [3:0] i_line;
  } apd_det_t;

  typedef enum logic [6:0] {
    ST_OFF   = 7'b0000001,
    ST_START = 7'b0000010,
    ST_RUN   = 7'b0000100,
    ST_HMUTE = 7'b0001000,
    ST_DISCH = 7'b0010000,
    ST_FMUTE = 7'b0100000,
    ST_LOW   = 7'b1000000
  } apd_state_t;
endpackage

// File: rtl/apd_ctrl.sv
// supervisory logic of a quad bridge amplifier: power-on, headroom, thermal, diagnostics
// assumes detector and pin inputs are asynchronous levels; registers on a plain 8-bit port
`timescale 1ns/10ps

// What this block does
// - bus mode undervoltage: clear instruction registers, off, fault low
// - start bit clears power flag, releases fault, starts
// - legacy undervoltage: amplifier off, fault untouched
// - low headroom: hard mute, then discharge capacitors
// - after discharge restart only above mute threshold
// - bus undervoltage sets power flag, waits start
// - standby low triggers fast mute from start-up or run
// - overvoltage switches output stage high impedance
// - pre-warning level selectable, shown and readable
// - legacy pre-warning level fixed at default
// - warm: gain reduction; too hot: channels off
// - fault output ORs fixed and enabled sources
// - fault low while failure persists, then released
// - standby pin second clip output, per channel
// - bus mode pin source selection
// - legacy fault sources fixed, no power flag
// - offset read sets latches, window clears, blocks
// - dc load detect ramps and classifies channels
// - status bits sticky, cleared by host read except the power flag
// - load code: 00 normal, 10 line, 11 open
// - instruction bits read zero after power-on
module apd_ctrl #(
  parameter int START_CYC = apd_pkg::START_CYC,
  parameter int FMUTE_CYC = apd_pkg::FMUTE_CYC
) (
  input  wire logic             clk_sys_i,
  input  wire logic             srst_i,
  input  wire logic             legacy_mode_i,
  input  wire logic             standby_in_i,
  output logic                  standby_out_o,
  output logic                  standby_oe_o,
  output logic                  fault_out_o,
  output logic                  fault_oe_o,
  input  wire apd_pkg::apd_det_t det_i,
  input  wire logic [2:0]       reg_addr_i,
  input  wire logic [7:0]       reg_wdata_i,
  input  wire logic             reg_we_i,
  input  wire logic             reg_re_i,
  output logic [7:0]            reg_rdata_o,
  output logic                  amp_on_o,
  output logic                  hard_mute_o,
  output logic                  fast_mute_o,
  output logic                  svr_discharge_o,
  output logic                  stage_hiz_o,
  output logic                  gain_reduce_o,
  output logic [3:0]            ch_off_o,
  output logic                  dc_ramp_o,
  output logic [1:0]            clip_level_o,
  output logic                  prewarn_sel_o
);
  localparam logic [apd_pkg::CNT_W-1:0] START_LAST = apd_pkg::CNT_W'(START_CYC - 1);
  localparam logic [apd_pkg::CNT_W-1:0] FMUTE_LAST = apd_pkg::CNT_W'(FMUTE_CYC - 1);

  apd_pkg::apd_det_t          det_s1_ff, det_ff;
  logic [1:0]                 pin_s1_ff, pin_ff;
  logic                       stb_d_ff;
  apd_pkg::apd_state_t        st_ff, nxt_st;
  logic [apd_pkg::CNT_W-1:0]  cnt_ff, nxt_cnt;
  logic [7:0]                 ctrl_ff, nxt_ctrl, fault_indicator_output_ff, nxt_fault_indicator_output, temp_ff, nxt_temp;
  logic [7:0]                 stat_ff, nxt_stat;
  logic [7:0]                 ch_ff [4];
  logic [7:0]                 nxt_ch [4];
  logic [3:0]                 offs_arm_ff, nxt_offs_arm;
  logic [7:0]                 rdata_ff, nxt_rdata;
  logic                       legacy, stb, por_evt, start_wr, stat_rd, classify;
  // recent history of our own standby pull, used to mask the synchronised pin
  logic                       oe_d1_ff, oe_d2_ff, stb_mask;
  logic [3:0]                 ch_rd, route;
  logic                       temp_en, load_en, clip_en, fault_pull, stb_pull;

  // two-flop synchronisers for detectors and pins
  always_ff @(posedge clk_sys_i) begin
    det_s1_ff <= det_i;
    det_ff    <= det_s1_ff;
    pin_s1_ff <= {legacy_mode_i, standby_in_i};
    pin_ff    <= pin_s1_ff;
    stb_d_ff  <= stb;
    // own pull delayed as far as the pin synchroniser lags it
    oe_d1_ff  <= standby_oe_o;
    oe_d2_ff  <= oe_d1_ff;
  end

  // decoded bus events and mode
  always_comb begin
    legacy   = pin_ff[1];
    // own clip pull on the standby pin must not read back as standby; the synchronised
    // pin lags the pull by up to two cycles, so the mask is held as long
    // limitation: a host pulling the pin low while we pull is not seen
    stb_mask = standby_oe_o | oe_d1_ff | oe_d2_ff;
    stb      = pin_ff[0] | stb_mask;
    // power-on on a rise of the masked level only, so a released pull is no power-on
    por_evt  = ~legacy & (det_ff.vp_below_reset | (stb & ~stb_d_ff));
    start_wr = reg_we_i & (reg_addr_i == apd_pkg::REG_CTRL) & reg_wdata_i[apd_pkg::CTRL_START];
    stat_rd  = reg_re_i & (reg_addr_i == apd_pkg::REG_STAT);
    for (int i = 0; i < 4; i++) begin
      ch_rd[i] = reg_re_i & (reg_addr_i == (apd_pkg::REG_CH0 + 3'(i)));
    end
  end

  // instruction registers and their power-on clear
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_fault_indicator_output = fault_indicator_output_ff;
    nxt_temp = temp_ff;
    if (reg_we_i) begin
      case (reg_addr_i)
        apd_pkg::REG_CTRL: nxt_ctrl = reg_wdata_i;
        apd_pkg::REG_FAULT_INDICATOR_OUTPUT: nxt_fault_indicator_output = reg_wdata_i;
        apd_pkg::REG_TEMP: nxt_temp = reg_wdata_i;
        default: ;
      endcase
    end
    if (por_evt) begin
      nxt_ctrl = apd_pkg::REG_RESET;
      nxt_fault_indicator_output = apd_pkg::REG_RESET;
      nxt_temp = apd_pkg::REG_RESET;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctrl_ff <= apd_pkg::REG_RESET;
      fault_indicator_output_ff <= apd_pkg::REG_RESET;
      temp_ff <= apd_pkg::REG_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
      fault_indicator_output_ff <= nxt_fault_indicator_output;
      temp_ff <= nxt_temp;
    end
  end

  // effective settings: legacy mode forces the all-zero setting
  always_comb begin
    route   = legacy ? 4'h0 : ctrl_ff[apd_pkg::CTRL_ROUTE_LSB +: 4];
    temp_en = legacy | ~fault_indicator_output_ff[apd_pkg::FAULT_INDICATOR_OUTPUT_TEMP_DIS];
    load_en = legacy | ~fault_indicator_output_ff[apd_pkg::FAULT_INDICATOR_OUTPUT_LOAD_DIS];
    clip_en = legacy | ~fault_indicator_output_ff[apd_pkg::FAULT_INDICATOR_OUTPUT_CLIP_DIS];
  end

  // start-up, headroom and shut-down sequencer
  always_comb begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff + 1'b1;
    classify = 1'b0;
    case (st_ff)
      apd_pkg::ST_OFF: begin
        nxt_cnt = '0;
        // bus mode waits for the start bit with the power flag cleared
        if (stb && (legacy || (ctrl_ff[apd_pkg::CTRL_START] && !stat_ff[apd_pkg::STAT_POR]))) begin
          nxt_st = apd_pkg::ST_START;
        end
      end
      apd_pkg::ST_START: begin
        if (!stb) begin
          nxt_st = apd_pkg::ST_FMUTE;
          nxt_cnt = '0;
        end else if (cnt_ff == START_LAST) begin
          nxt_st   = apd_pkg::ST_RUN;
          classify = 1'b1;
        end
      end
      apd_pkg::ST_RUN: begin
        nxt_cnt = '0;
        if (!stb) begin
          nxt_st = apd_pkg::ST_FMUTE;
        end else if (det_ff.hr_low) begin
          nxt_st = apd_pkg::ST_HMUTE;
        end
      end
      apd_pkg::ST_HMUTE: begin
        nxt_st = apd_pkg::ST_DISCH;
      end
      apd_pkg::ST_DISCH, apd_pkg::ST_LOW: begin
        nxt_cnt = '0;
        if (det_ff.svr_empty || st_ff == apd_pkg::ST_LOW) begin
          nxt_st = det_ff.vp_low_mute ? apd_pkg::ST_LOW : apd_pkg::ST_START;
        end
      end
      apd_pkg::ST_FMUTE: begin
        if (cnt_ff == FMUTE_LAST) begin
          nxt_st = apd_pkg::ST_OFF;
        end
      end
      default: nxt_st = apd_pkg::ST_OFF;
    endcase
    if (por_evt || det_ff.vp_below_reset) begin
      nxt_st  = apd_pkg::ST_OFF;
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_ff  <= apd_pkg::ST_OFF;
      cnt_ff <= '0;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end

  // global status: sticky, read clears all but the power-on flag, a new event wins over the clear
  always_comb begin
    nxt_stat = stat_rd ? (stat_ff & 8'h80) : stat_ff;
    nxt_stat[apd_pkg::STAT_PW]     = nxt_stat[apd_pkg::STAT_PW] | det_ff.prewarn;
    nxt_stat[apd_pkg::STAT_GR]     = nxt_stat[apd_pkg::STAT_GR] | det_ff.gain_red;
    nxt_stat[apd_pkg::STAT_LOWBAT] = nxt_stat[apd_pkg::STAT_LOWBAT] | det_ff.low_bat;
    nxt_stat[apd_pkg::STAT_OV]     = nxt_stat[apd_pkg::STAT_OV] | det_ff.over_volt;
    nxt_stat[apd_pkg::STAT_TOFF]   = nxt_stat[apd_pkg::STAT_TOFF] | det_ff.t_off;
    if (start_wr) begin
      nxt_stat[apd_pkg::STAT_POR] = 1'b0;
    end
    if (por_evt) begin
      nxt_stat[apd_pkg::STAT_POR] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      stat_ff <= apd_pkg::REG_RESET;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // per-channel status, offset latch and load code
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      always_comb begin
        nxt_ch[g]       = ch_ff[g];
        nxt_offs_arm[g] = offs_arm_ff[g];
        if (ch_rd[g]) begin
          nxt_ch[g][apd_pkg::CH_CLIP]  = 1'b0;
          nxt_ch[g][apd_pkg::CH_SHORT] = 1'b0;
          nxt_ch[g][apd_pkg::CH_MISS]  = 1'b0;
        end
        nxt_ch[g][apd_pkg::CH_CLIP]  = nxt_ch[g][apd_pkg::CH_CLIP] | det_ff.clip_ch[g];
        nxt_ch[g][apd_pkg::CH_SHORT] = nxt_ch[g][apd_pkg::CH_SHORT] | det_ff.short_ch[g];
        nxt_ch[g][apd_pkg::CH_MISS]  = nxt_ch[g][apd_pkg::CH_MISS] | det_ff.miss_ch[g];
        if (det_ff.in_window[g]) begin
          nxt_ch[g][apd_pkg::CH_OFFS] = 1'b0;
          nxt_offs_arm[g]             = 1'b0;
        end
        if (ch_rd[g] && !legacy) begin
          nxt_ch[g][apd_pkg::CH_OFFS] = 1'b1;
          nxt_offs_arm[g]             = 1'b1;
        end
        if (classify) begin
          if (!ctrl_ff[apd_pkg::CTRL_DCLD] || legacy) begin
            nxt_ch[g][apd_pkg::CH_LOAD_LSB +: 2] = apd_pkg::LOAD_NORMAL;
          end else if (det_ff.i_open[g]) begin
            nxt_ch[g][apd_pkg::CH_LOAD_LSB +: 2] = apd_pkg::LOAD_OPEN;
          end else if (det_ff.i_line[g]) begin
            nxt_ch[g][apd_pkg::CH_LOAD_LSB +: 2] = apd_pkg::LOAD_LINE;
          end else begin
            nxt_ch[g][apd_pkg::CH_LOAD_LSB +: 2] = apd_pkg::LOAD_NORMAL;
          end
        end
      end

      always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
          ch_ff[g]       <= apd_pkg::REG_RESET;
          offs_arm_ff[g] <= 1'b0;
        end else begin
          ch_ff[g]       <= nxt_ch[g];
          offs_arm_ff[g] <= nxt_offs_arm[g];
        end
      end
    end
  endgenerate

  // fault and standby pin sources, live except the latched power-on flag
  always_comb begin
    fault_pull = (~legacy & stat_ff[apd_pkg::STAT_POR])
               | det_ff.low_bat | det_ff.over_volt
               | (temp_en & det_ff.prewarn)
               | (load_en & (|det_ff.short_ch | |det_ff.miss_ch))
               | (clip_en & |(det_ff.clip_ch & ~route));
    stb_pull   = ~legacy & clip_en & |(det_ff.clip_ch & route);
  end

  // read data one cycle after the strobe
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_re_i) begin
      case (reg_addr_i)
        apd_pkg::REG_CTRL: nxt_rdata = ctrl_ff;
        apd_pkg::REG_FAULT_INDICATOR_OUTPUT: nxt_rdata = fault_indicator_output_ff;
        apd_pkg::REG_TEMP: nxt_rdata = temp_ff;
        apd_pkg::REG_STAT: nxt_rdata = stat_ff;
        default:           nxt_rdata = ch_ff[reg_addr_i[1:0]];
      endcase
    end
  end

  // registered pin and amplifier controls
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_ff        <= 8'h00;
      fault_oe_o      <= 1'b0;
      standby_oe_o    <= 1'b0;
      amp_on_o        <= 1'b0;
      hard_mute_o     <= 1'b0;
      fast_mute_o     <= 1'b0;
      svr_discharge_o <= 1'b0;
      stage_hiz_o     <= 1'b0;
      gain_reduce_o   <= 1'b0;
      ch_off_o        <= 4'h0;
      dc_ramp_o       <= 1'b0;
      clip_level_o    <= apd_pkg::CLIP_LVL_LEGACY;
      prewarn_sel_o   <= apd_pkg::PW_SEL_LEGACY;
    end else begin
      rdata_ff        <= nxt_rdata;
      fault_oe_o      <= fault_pull;
      standby_oe_o    <= stb_pull;
      amp_on_o        <= nxt_st inside {apd_pkg::ST_START, apd_pkg::ST_RUN, apd_pkg::ST_HMUTE,
                                        apd_pkg::ST_FMUTE};
      hard_mute_o     <= nxt_st inside {apd_pkg::ST_HMUTE, apd_pkg::ST_DISCH};
      fast_mute_o     <= nxt_st == apd_pkg::ST_FMUTE;
      svr_discharge_o <= nxt_st == apd_pkg::ST_DISCH;
      stage_hiz_o     <= det_ff.over_volt;
      gain_reduce_o   <= det_ff.gain_red;
      ch_off_o        <= {4{det_ff.t_off}} | det_ff.short_ch | det_ff.miss_ch;
      dc_ramp_o       <= ~legacy & ctrl_ff[apd_pkg::CTRL_DCLD] & (nxt_st == apd_pkg::ST_START);
      clip_level_o    <= legacy ? apd_pkg::CLIP_LVL_LEGACY : fault_indicator_output_ff[apd_pkg::FAULT_INDICATOR_OUTPUT_LVL_LSB +: 2];
      prewarn_sel_o   <= legacy ? apd_pkg::PW_SEL_LEGACY : temp_ff[apd_pkg::TEMP_PW_SEL];
    end
  end

  // open-drain pins only ever pull low
  assign fault_out_o   = 1'b0;
  assign standby_out_o = 1'b0;
  assign reg_rdata_o   = rdata_ff;
endmodule // apd_ctrl

// File: testbench/apd_ctrl_properties.sv
// concurrent checks on the ports of the amplifier supervisory block
// assumes detector and pin levels pass a two-flop synchroniser before use
`timescale 1ns/10ps
module apd_ctrl_properties (
  input wire logic              clk_sys_i,
  input wire logic              srst_i,
  input wire logic              legacy_mode_i,
  input wire logic              standby_in_i,
  input wire logic              standby_out_o,
  input wire logic              fault_out_o,
  input wire logic              fault_oe_o,
  input wire apd_pkg::apd_det_t det_i,
  input wire logic              amp_on_o,
  input wire logic              hard_mute_o,
  input wire logic              fast_mute_o,
  input wire logic              svr_discharge_o,
  input wire logic              stage_hiz_o,
  input wire logic [3:0]        ch_off_o,
  input wire logic [1:0]        clip_level_o,
  input wire logic              prewarn_sel_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  // supply and thermal supervision
  por_fault_low_a: assert property ((!legacy_mode_i && det_i.vp_below_reset) [*5] |-> ##[0:3] (fault_oe_o && !amp_on_o))
    else $error("fault pin not low or amplifier on after supply drop");
  legacy_drop_off_a: assert property ((legacy_mode_i && det_i.vp_below_reset) [*5] |-> ##[0:3] !amp_on_o)
    else $error("amplifier on after supply drop in legacy mode");
  overvolt_hiz_a: assert property (det_i.over_volt [*5] |-> ##[0:3] (stage_hiz_o && fault_oe_o))
    else $error("output stage not high impedance on overvoltage");
  hot_all_off_a: assert property (det_i.t_off [*5] |-> ##[0:3] (ch_off_o == 4'hF))
    else $error("channels not off at shut-down temperature");
  // mute sequencing
  stby_fast_mute_a: assert property ($rose(fast_mute_o) |-> !($past(standby_in_i, 2) && $past(standby_in_i, 3)))
    else $error("fast mute without standby low");
  mute_before_disch_a: assert property ($rose(svr_discharge_o) |-> $past(hard_mute_o))
    else $error("discharge started before hard mute");
  disch_muted_a: assert property (svr_discharge_o |-> hard_mute_o)
    else $error("discharge without hard mute");
  // legacy fixed settings and pin kind
  legacy_fixed_a: assert property (legacy_mode_i [*5] |-> ##[0:2] (prewarn_sel_o == apd_pkg::PW_SEL_LEGACY
    && clip_level_o == apd_pkg::CLIP_LVL_LEGACY))
    else $error("legacy levels not fixed");
  legacy_clip_a: assert property ((legacy_mode_i && det_i.clip_ch != 4'h0) [*5] |-> ##[0:3] fault_oe_o)
    else $error("legacy clip not on fault pin");
  drain_only_a: assert property (fault_out_o == 1'b0)
    else $error("fault pin driven high");
  stby_drain_a: assert property (standby_out_o == 1'b0)
    else $error("standby pin driven high");

  // main scenarios reached
  start_c: cover property ($rose(amp_on_o));
  disch_c: cover property ($rose(svr_discharge_o));
  fmute_c: cover property ($rose(fast_mute_o));
endmodule // apd_ctrl_properties

// File: testbench/apd_host_model.sv
// host side of the plain register port: one-cycle write and read strobes
// assumes read data stand only in the cycle after the read strobe
`timescale 1ns/10ps
module apd_host_model (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic [2:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_we_o,
  output logic            reg_re_o
);
  // idle bus at time zero
  initial begin
    reg_addr_o  = 3'h0;
    reg_wdata_o = 8'h00;
    reg_we_o    = 1'b0;
    reg_re_o    = 1'b0;
  end
  // one write cycle; released data inverted so stale values never match
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_we_o    <= 1'b1;
    @(posedge clk_sys_i);
    reg_we_o    <= 1'b0;
    reg_wdata_o <= ~d;
  endtask
  // one read cycle, data taken in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_re_o   <= 1'b1;
    @(posedge clk_sys_i);
    reg_re_o   <= 1'b0;
    #1;
    d = reg_rdata_i;
  endtask
  // start command: control write with the start bit set
  task automatic start(input logic [7:0] d);
    wr(3'h0, d | 8'h01);
  endtask
endmodule // apd_host_model

// File: testbench/testbench.sv
// self-checking bench of the supervisory block driven through the host model
// assumes a 100 MHz clock and detector levels driven as plain logic
`timescale 1ns/10ps
module testbench;
  logic              clk_sys_i;
  logic              srst_i;
  logic              legacy_mode_i;
  logic              stby_drv;
  logic              stby_pin;
  apd_pkg::apd_det_t det_i;
  logic [2:0]        reg_addr_i;
  logic [7:0]        reg_wdata_i;
  logic              reg_we_i;
  logic              reg_re_i;
  logic [7:0]        reg_rdata_o;
  logic              standby_out_o;
  logic              standby_oe_o;
  logic              fault_out_o;
  logic              fault_oe_o;
  logic              amp_on_o;
  logic              hard_mute_o;
  logic              fast_mute_o;
  logic              svr_discharge_o;
  logic              stage_hiz_o;
  logic              gain_reduce_o;
  logic [3:0]        ch_off_o;
  logic              dc_ramp_o;
  logic [1:0]        clip_level_o;
  logic              prewarn_sel_o;
  logic [3:0]        mon;
  logic [7:0]        rv;
  int                failures;
  int                n_checks;

  // standby wire: our drive low or the block pulling low
  assign stby_pin = stby_drv & ~standby_oe_o;
  assign mon      = {amp_on_o, svr_discharge_o, fast_mute_o, fault_oe_o};

  apd_ctrl #(.START_CYC(8), .FMUTE_CYC(4)) u_apd_ctrl (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .legacy_mode_i(legacy_mode_i), .standby_in_i(stby_pin),
    .standby_out_o(standby_out_o), .standby_oe_o(standby_oe_o), .fault_out_o(fault_out_o),
    .fault_oe_o(fault_oe_o), .det_i(det_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .amp_on_o(amp_on_o),
    .hard_mute_o(hard_mute_o), .fast_mute_o(fast_mute_o), .svr_discharge_o(svr_discharge_o),
    .stage_hiz_o(stage_hiz_o), .gain_reduce_o(gain_reduce_o), .ch_off_o(ch_off_o), .dc_ramp_o(dc_ramp_o),
    .clip_level_o(clip_level_o), .prewarn_sel_o(prewarn_sel_o));

  apd_host_model u_apd_host_model (
    .clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_we_o(reg_we_i), .reg_re_o(reg_re_i));

  // 100 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
    u_apd_host_model.rd(a, rv);
    chk(rv & m, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // bounded wait for one monitored output to reach a level
  task automatic wait_bit(input int i, input logic v);
    for (int k = 0; k < 400; k++) begin
      @(posedge clk_sys_i);
      #1;
      if (mon[i] === v) return;
    end
    failures++;
    $display("Error at %0t: wait %0d timed out, got %h expected %h", $time, i, mon[i], v);
    complete_run();
  endtask
  // supply drop pulse
  task automatic drop();
    det_i.vp_below_reset <= 1'b1;
    tick(6);
    det_i.vp_below_reset <= 1'b0;
    tick(4);
  endtask

  // main sequence
  initial begin
    failures = 0;
    n_checks = 0;
    srst_i = 1'b1;
    legacy_mode_i = 1'b0;
    stby_drv = 1'b1;
    det_i = '0;
    tick(12);
    srst_i <= 1'b0;
    tick(2);
    drop();
    chkb(fault_oe_o, 1'b1);
    chkb(amp_on_o, 1'b0);
    rdchk(3'h3, 8'h80, 8'h80);
    for (int a = 0; a < 3; a++) rdchk(3'(a), 8'hFF, 8'h00);
    u_apd_host_model.start(8'h02);
    wait_bit(3, 1'b1);
    chkb(fault_oe_o, 1'b0);
    rdchk(3'h3, 8'h80, 8'h00);
    tick(12);
    // clip routing, channel 1 to the standby pin
    u_apd_host_model.wr(3'h0, 8'h13);
    det_i.clip_ch <= 4'h2;
    tick(6);
    chkb(standby_oe_o, 1'b1);
    chkb(fault_oe_o, 1'b0);
    det_i.clip_ch <= 4'h1;
    tick(6);
    chkb(standby_oe_o, 1'b0);
    chkb(fault_oe_o, 1'b1);
    u_apd_host_model.wr(3'h1, 8'h42);
    tick(3);
    chkb(fault_oe_o, 1'b0);
    chk({6'h00, clip_level_o}, 8'h02);
    det_i.clip_ch <= 4'h0;
    // pre-warning level, pin and sticky status
    u_apd_host_model.wr(3'h2, 8'h10);
    tick(3);
    chkb(prewarn_sel_o, 1'b1);
    det_i.prewarn <= 1'b1;
    tick(6);
    chkb(fault_oe_o, 1'b1);
    det_i.prewarn <= 1'b0;
    tick(6);
    chkb(fault_oe_o, 1'b0);
    rdchk(3'h3, 8'h01, 8'h01);
    rdchk(3'h3, 8'h01, 8'h00);
    // offset latch set by read, cleared by window
    u_apd_host_model.rd(3'h4, rv);
    rdchk(3'h4, 8'h04, 8'h04);
    det_i.in_window <= 4'h1;
    tick(5);
    det_i.in_window <= 4'h0;
    tick(1);
    rdchk(3'h4, 8'h04, 8'h00);
    // headroom loss, restart with load classification
    det_i.i_open <= 4'h1;
    det_i.i_line <= 4'h2;
    det_i.hr_low <= 1'b1;
    wait_bit(2, 1'b1);
    chkb(hard_mute_o, 1'b1);
    det_i.hr_low <= 1'b0;
    det_i.svr_empty <= 1'b1;
    wait_bit(2, 1'b0);
    chkb(dc_ramp_o, 1'b1);
    det_i.svr_empty <= 1'b0;
    tick(12);
    rdchk(3'h4, 8'h30, 8'h30);
    rdchk(3'h5, 8'h30, 8'h20);
    rdchk(3'h6, 8'h30, 8'h00);
    // restart held off below the low-supply mute threshold
    det_i.vp_low_mute <= 1'b1;
    det_i.hr_low <= 1'b1;
    wait_bit(2, 1'b1);
    det_i.hr_low <= 1'b0;
    det_i.svr_empty <= 1'b1;
    wait_bit(2, 1'b0);
    tick(20);
    chkb(amp_on_o, 1'b0);
    det_i.vp_low_mute <= 1'b0;
    wait_bit(3, 1'b1);
    det_i.svr_empty <= 1'b0;
    tick(12);
    // overvoltage, thermal and short events
    det_i.over_volt <= 1'b1;
    det_i.t_off <= 1'b1;
    det_i.gain_red <= 1'b1;
    det_i.short_ch <= 4'h4;
    tick(8);
    chkb(gain_reduce_o, 1'b1);
    det_i <= '0;
    tick(6);
    rdchk(3'h3, 8'h1A, 8'h1A);
    rdchk(3'h6, 8'h02, 8'h02);
    // supply drop in mid-run waits for a new start
    drop();
    chkb(amp_on_o, 1'b0);
    tick(20);
    chkb(amp_on_o, 1'b0);
    rdchk(3'h0, 8'hFF, 8'h00);
    rdchk(3'h2, 8'hFF, 8'h00);
    u_apd_host_model.start(8'h00);
    wait_bit(3, 1'b1);
    tick(12);
    stby_drv <= 1'b0;
    wait_bit(1, 1'b1);
    wait_bit(3, 1'b0);
    // legacy mode: fixed levels, no power-on indication
    legacy_mode_i <= 1'b1;
    stby_drv <= 1'b1;
    wait_bit(3, 1'b1);
    u_apd_host_model.wr(3'h2, 8'h10);
    tick(3);
    chkb(prewarn_sel_o, 1'b0);
    det_i.clip_ch <= 4'h1;
    tick(6);
    chkb(fault_oe_o, 1'b1);
    det_i.clip_ch <= 4'h0;
    tick(6);
    det_i.vp_below_reset <= 1'b1;
    tick(6);
    chkb(amp_on_o, 1'b0);
    chkb(fault_oe_o, 1'b0);
    det_i.vp_below_reset <= 1'b0;
    tick(4);
    complete_run();
  end
endmodule // testbench

bind apd_ctrl apd_ctrl_properties u_apd_ctrl_properties (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .legacy_mode_i(legacy_mode_i), .standby_in_i(standby_in_i),
  .standby_out_o(standby_out_o),
  .fault_out_o(fault_out_o), .fault_oe_o(fault_oe_o), .det_i(det_i), .amp_on_o(amp_on_o),
  .hard_mute_o(hard_mute_o), .fast_mute_o(fast_mute_o), .svr_discharge_o(svr_discharge_o),
  .stage_hiz_o(stage_hiz_o), .ch_off_o(ch_off_o), .clip_level_o(clip_level_o), .prewarn_sel_o(prewarn_sel_o));
